// >>> rtl/safe_torque_off_monitor.sv
// safe torque off input and monitor logic with an apb register slave
// assumes shut-off contacts arrive asynchronously; monitor outputs drive
// open-collector stages outside (1 = conducting)
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps

module safe_torque_off_monitor
(
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic i_shutoff_in_a,          // contact a, 1 = closed
   input wire logic i_shutoff_in_b,          // contact b, 1 = closed
   input wire logic i_forced_stop_decel_in,  // forced stop 2 request, 1 = decelerate
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic o_base_drive_en,             // power stage gate enable
   output logic o_torque_off_mon_a,          // 1 = monitor a conducting
   output logic o_torque_off_mon_b,          // 1 = monitor b conducting
   output logic o_torque_off_mon_common,     // 1 = path across monitors conducting
   output logic o_decel_active,              // forced-stop deceleration running
   output logic o_timing_alarm,              // torque-off timing alarm
   output logic o_irq                        // level interrupt
);

   // ------------------------------------------------------------------
   // channel filters
   // ------------------------------------------------------------------
   sto_monitor_pkg::chan_state_t chan;   // filtered channel states
   logic chg_a;                          // channel a change pulse
   logic chg_b;                          // channel b change pulse

   // channel a: open contact is a torque-off request
   sto_input_filter u_filt_a
   (
      .i_mclk(i_mclk),
      .i_resetn(i_resetn),
      .i_pin_closed(i_shutoff_in_a),
      .o_torque_off(chan.off_a),
      .o_changed(chg_a)
   );

   // channel b: same treatment
   sto_input_filter u_filt_b
   (
      .i_mclk(i_mclk),
      .i_resetn(i_resetn),
      .i_pin_closed(i_shutoff_in_b),
      .o_torque_off(chan.off_b),
      .o_changed(chg_b)
   );

   // ------------------------------------------------------------------
   // synchronised forced-stop input
   // ------------------------------------------------------------------
   logic fs1_r;   // first stage
   logic fs2_r;   // second stage

   // two flops on the forced-stop pin
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         fs1_r <= 1'b0;
         fs2_r <= 1'b0;
      end
      else
      begin
         fs1_r <= i_forced_stop_decel_in;
         fs2_r <= fs1_r;
      end
   end

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   logic rotating_r;      // motor rotating, from drive core software
   logic torque_mode_r;   // torque control mode selected
   logic alarm_r;         // timing alarm latched
   logic [3:0] irq_stat_r; // sticky events
   logic [3:0] irq_en_r;   // event enables
   logic wr_acc;          // write access phase
   logic rd_acc;          // read access phase
   logic [3:0] ev;        // this cycle's events
   logic [3:0] clr;       // this cycle's clear request
   logic alarm_set;       // alarm raise condition
   logic any_chg;         // either filtered channel moved

   assign wr_acc = i_psel && i_penable && i_pwrite;
   assign rd_acc = i_psel && i_penable && !i_pwrite;
   assign any_chg = chg_a || chg_b;
   // channel entering torque-off while the motor still turns
   // a release on one channel must not hide an entry on the other
   assign alarm_set = rotating_r && ((chg_a && chan.off_a) || (chg_b && chan.off_b));

   // motion and mode control written by software
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         rotating_r <= 1'b0;
         torque_mode_r <= 1'b0;
      end
      else if (wr_acc && i_paddr == sto_monitor_pkg::ADDR_CTRL)
      begin
         rotating_r <= i_pwdata[sto_monitor_pkg::CT_ROTATING];
         torque_mode_r <= i_pwdata[sto_monitor_pkg::CT_TORQUE_MODE];
      end
   end

   // timing alarm: set wins over the clear
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
         alarm_r <= 1'b0;
      else if (alarm_set)
         alarm_r <= 1'b1;
      else if (wr_acc && i_paddr == sto_monitor_pkg::ADDR_CTRL &&
               i_pwdata[sto_monitor_pkg::CT_ALARM_CLR])
         alarm_r <= 1'b0;
   end

   // event collection
   always_comb
   begin
      ev = 4'h0;
      ev[sto_monitor_pkg::EV_CHG_A] = chg_a;
      ev[sto_monitor_pkg::EV_CHG_B] = chg_b;
      ev[sto_monitor_pkg::EV_MISMATCH] = any_chg && (chan.off_a != chan.off_b);
      ev[sto_monitor_pkg::EV_ALARM] = alarm_set;
      clr = 4'h0;
      if (wr_acc && i_paddr == sto_monitor_pkg::ADDR_IRQ_CLR)
         clr = i_pwdata[3:0];
   end

   // sticky status: a new event beats a simultaneous clear
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
         irq_stat_r <= 4'h0;
      else
         irq_stat_r <= (irq_stat_r & ~clr) | ev;
   end

   // enable register
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
         irq_en_r <= 4'h0;
      else if (wr_acc && i_paddr == sto_monitor_pkg::ADDR_IRQ_EN)
         irq_en_r <= i_pwdata[3:0];
   end

   // ------------------------------------------------------------------
   // apb read path, one-cycle answer with zero wait states
   // ------------------------------------------------------------------
   logic [31:0] rd_nxt;   // read mux
   logic err_nxt;         // unmapped address

   always_comb
   begin
      rd_nxt = sto_monitor_pkg::RD_ZERO;
      err_nxt = 1'b0;
      unique case (i_paddr)
         sto_monitor_pkg::ADDR_STATE:
         begin
            rd_nxt[sto_monitor_pkg::ST_OFF_A] = chan.off_a;
            rd_nxt[sto_monitor_pkg::ST_OFF_B] = chan.off_b;
            rd_nxt[sto_monitor_pkg::ST_BASE_CUT] = !o_base_drive_en;
            rd_nxt[sto_monitor_pkg::ST_BOTH_OFF] = o_torque_off_mon_common;
            rd_nxt[sto_monitor_pkg::ST_DECEL_OK] = !torque_mode_r;
            rd_nxt[sto_monitor_pkg::ST_ALARM] = alarm_r;
         end
         sto_monitor_pkg::ADDR_CTRL:
         begin
            rd_nxt[sto_monitor_pkg::CT_ROTATING] = rotating_r;
            rd_nxt[sto_monitor_pkg::CT_TORQUE_MODE] = torque_mode_r;
         end
         sto_monitor_pkg::ADDR_IRQ_STAT: rd_nxt[3:0] = irq_stat_r;
         sto_monitor_pkg::ADDR_IRQ_EN: rd_nxt[3:0] = irq_en_r;
         sto_monitor_pkg::ADDR_IRQ_CLR: rd_nxt = sto_monitor_pkg::RD_ZERO;
         default: err_nxt = 1'b1;
      endcase
   end

   // bus outputs registered; pready rises in the cycle after setup
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_prdata <= sto_monitor_pkg::RD_ZERO;
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
      end
      else
      begin
         o_pready <= i_psel && !i_penable;
         o_pslverr <= i_psel && !i_penable && err_nxt;
         o_prdata <= (i_psel && !i_penable && !i_pwrite) ? rd_nxt : sto_monitor_pkg::RD_ZERO;
      end
   end

   // ------------------------------------------------------------------
   // power stage and monitor outputs
   // ------------------------------------------------------------------
   // every change of filtered state reaches the outputs next cycle
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_base_drive_en <= 1'b0;
         o_torque_off_mon_a <= 1'b1;
         o_torque_off_mon_b <= 1'b1;
         o_torque_off_mon_common <= 1'b1;
      end
      else
      begin
         // either channel off cuts the base drive
         o_base_drive_en <= !(chan.off_a || chan.off_b);
         o_torque_off_mon_a <= chan.off_a;
         o_torque_off_mon_b <= chan.off_b;
         o_torque_off_mon_common <= chan.off_a && chan.off_b;
      end
   end

   // forced-stop deceleration withheld in torque mode and once cut off
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
         o_decel_active <= 1'b0;
      else
         o_decel_active <= fs2_r && !torque_mode_r && !(chan.off_a || chan.off_b);
   end

   // alarm and interrupt outputs
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_timing_alarm <= 1'b0;
         o_irq <= 1'b0;
      end
      else
      begin
         o_timing_alarm <= alarm_r;
         o_irq <= |(((irq_stat_r & ~clr) | ev) & irq_en_r);
      end
   end

endmodule

// >>> rtl/sto_input_filter.sv
// one shut-off channel: pin synchroniser plus test-pulse filter
// assumes the pin level is asynchronous; high means contact closed (released)
`timescale 1ns/100ps

module sto_input_filter
(
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic i_pin_closed,   // raw contact level, 1 = closed
   output logic o_torque_off,       // filtered torque-off request
   output logic o_changed           // one-cycle pulse on filtered change
);

   // ------------------------------------------------------------------
   // synchroniser
   // ------------------------------------------------------------------
   logic sync1_r;   // first stage, read only by second
   logic sync2_r;   // second stage, safe to use

   // two flops before any logic looks at the pin
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
      end
      else
      begin
         sync1_r <= i_pin_closed;
         sync2_r <= sync1_r;
      end
   end

   // ------------------------------------------------------------------
   // filter
   // ------------------------------------------------------------------
   logic [16:0] cnt_r;   // cycles the pin has been open
   logic off_r;          // filtered state, starts off for safety

   // count open time; open pulses up to the test limit are ignored
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
         cnt_r <= sto_monitor_pkg::FILT_ZERO;
      else if (sync2_r)
         cnt_r <= sto_monitor_pkg::FILT_ZERO;
      else if (cnt_r <= sto_monitor_pkg::FILT_LIMIT)
         cnt_r <= cnt_r + 17'h0_0001;
   end

   // enter torque-off once open longer than the test limit, leave on close
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         off_r <= 1'b1;
         o_changed <= 1'b0;
      end
      else
      begin
         if (sync2_r)
            off_r <= 1'b0;   // closed: released, driving
         else if (cnt_r >= sto_monitor_pkg::FILT_LIMIT)
            off_r <= 1'b1;   // this open sample is one past the test limit: torque-off
         o_changed <= (sync2_r && off_r) ||
                      (!sync2_r && !off_r && cnt_r >= sto_monitor_pkg::FILT_LIMIT);
      end
   end

   assign o_torque_off = off_r;

endmodule

// >>> shared/sto_monitor_pkg.sv
// package for the safe torque off monitor: register map, timing, shared types
// assumes a 100 MHz clock and a 32-bit apb register bus
package sto_monitor_pkg;

   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 10;         // clock period in ns
   localparam int unsigned TEST_PULSE_MAX_US = 1000;   // longest tolerated off pulse, us (1 ms)
   // least time: round up to whole cycles
   localparam int unsigned TEST_PULSE_CYC =
      (TEST_PULSE_MAX_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned FILT_W = 17;                // counter width, holds TEST_PULSE_CYC
   localparam logic [16:0] FILT_LIMIT = 17'(TEST_PULSE_CYC);
   localparam logic [16:0] FILT_ZERO = 17'h0_0000;

   // ------------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [11:0] ADDR_STATE = 12'h000;   // ro: filtered channel state, base cut, decel offer and alarm
   localparam logic [11:0] ADDR_CTRL = 12'h004;    // rw: motion status from drive core
   localparam logic [11:0] ADDR_IRQ_STAT = 12'h008; // ro: sticky events
   localparam logic [11:0] ADDR_IRQ_EN = 12'h00C;  // rw: event enables
   localparam logic [11:0] ADDR_IRQ_CLR = 12'h010; // wo: write one to clear

   // state register fields
   localparam int unsigned ST_OFF_A = 0;      // channel a in torque-off
   localparam int unsigned ST_OFF_B = 1;      // channel b in torque-off
   localparam int unsigned ST_BASE_CUT = 2;   // base drive cut
   localparam int unsigned ST_BOTH_OFF = 3;   // both off (common path)
   localparam int unsigned ST_DECEL_OK = 4;   // forced-stop deceleration offered
   localparam int unsigned ST_ALARM = 5;      // timing alarm latched

   // control register fields
   localparam int unsigned CT_ROTATING = 0;   // motor still rotating
   localparam int unsigned CT_TORQUE_MODE = 1; // torque control mode
   localparam int unsigned CT_ALARM_CLR = 2;  // write one clears timing alarm

   // event bits
   localparam int unsigned EV_CHG_A = 0;      // channel a filtered change
   localparam int unsigned EV_CHG_B = 1;      // channel b filtered change
   localparam int unsigned EV_MISMATCH = 2;   // channels disagree (single channel off)
   localparam int unsigned EV_ALARM = 3;      // timing alarm raised
   localparam int unsigned EV_W = 4;

   localparam logic [31:0] RD_ZERO = 32'h0000_0000;

   // ------------------------------------------------------------------
   // types
   // ------------------------------------------------------------------
   typedef struct packed {
      logic off_a;   // channel a filtered torque-off
      logic off_b;   // channel b filtered torque-off
   } chan_state_t;

   typedef struct packed {
      logic mon_a;      // monitor a conducting
      logic mon_b;      // monitor b conducting
      logic mon_common; // path across both monitors conducting
   } mon_out_t;

endpackage

// >>> verification/safety_unit_model.sv
// safety unit model: opens each shut-off contact on its own request, both on a test pulse
// assumes the bench drives its requests right after the rising edge
`timescale 1ns/100ps
module safety_unit_model
#(
   parameter int unsigned PULSE_CYC = 1000 // test pulse length, under 1 ms
)
(
   input wire logic i_mclk,
   input wire logic i_off_a_req, // open contact a
   input wire logic i_off_b_req, // open contact b
   input wire logic i_pulse,     // start one test pulse on both
   output logic o_contact_a,     // 1 = closed
   output logic o_contact_b      // 1 = closed
);
   logic [16:0] pulse_r = 17'h0_0000; // test pulse cycles left
   // reload only from idle so a pulse never outlasts its length
   always @(posedge i_mclk)
   begin
      if (i_pulse && pulse_r == 17'h0_0000)
         pulse_r <= 17'(PULSE_CYC);
      else if (pulse_r != 17'h0_0000)
         pulse_r <= pulse_r - 17'h0_0001;
   end
   // each request opens its own contact, a test pulse opens both; a lone request is a bench-made fault
   assign o_contact_a = !(i_off_a_req || pulse_r != 17'h0_0000);
   assign o_contact_b = !(i_off_b_req || pulse_r != 17'h0_0000);
endmodule

// >>> verification/sto_monitor_properties.sv
// checker: port-level timing of the safe torque off monitor
// assumes it is bound onto safe_torque_off_monitor, one clock domain
`timescale 1ns/100ps
module sto_monitor_checker
(
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic i_shutoff_in_a,
   input wire logic i_shutoff_in_b,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic o_pready,
   input wire logic o_base_drive_en,
   input wire logic o_torque_off_mon_a,
   input wire logic o_torque_off_mon_b,
   input wire logic o_torque_off_mon_common,
   input wire logic o_timing_alarm
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // open-sample count at which a channel must already be off
   localparam logic [16:0] SET_AT = 17'(sto_monitor_pkg::TEST_PULSE_CYC + 8);
   // open-sample count seen when a monitor turns on: limit plus one open
   // sample, two sync stages and the output flop
   localparam logic [16:0] ROSE_AT = 17'(sto_monitor_pkg::TEST_PULSE_CYC + 4);
   logic [16:0] low_a_r; // consecutive open samples, contact a
   logic [16:0] low_b_r; // consecutive open samples, contact b
   // count open samples; saturate so the count never wraps
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         low_a_r <= sto_monitor_pkg::FILT_ZERO;
         low_b_r <= sto_monitor_pkg::FILT_ZERO;
      end
      else
      begin
         low_a_r <= i_shutoff_in_a ? 17'h0_0000 : low_a_r + 17'(low_a_r != SET_AT);
         low_b_r <= i_shutoff_in_b ? 17'h0_0000 : low_b_r + 17'(low_b_r != SET_AT);
      end
   end
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_resetn);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   property p_base_cut; o_base_drive_en == !(o_torque_off_mon_a || o_torque_off_mon_b); endproperty
   a_base_cut: assert property (p_base_cut)
      else $error("drive enabled with a channel off");
   property p_common; o_torque_off_mon_common == (o_torque_off_mon_a && o_torque_off_mon_b); endproperty
   a_common: assert property (p_common)
      else $error("common path wrong");
   property p_rel_a; i_shutoff_in_a [*6] |-> !o_torque_off_mon_a; endproperty
   a_rel_a: assert property (p_rel_a)
      else $error("monitor a on while released");
   property p_rel_b; i_shutoff_in_b [*6] |-> !o_torque_off_mon_b; endproperty
   a_rel_b: assert property (p_rel_b)
      else $error("monitor b on while released");
   property p_filt_a; $rose(o_torque_off_mon_a) |-> low_a_r == ROSE_AT; endproperty
   a_filt_a: assert property (p_filt_a)
      else $error("monitor a on after short pulse");
   property p_set_b; low_b_r == SET_AT |-> o_torque_off_mon_b; endproperty
   a_set_b: assert property (p_set_b)
      else $error("monitor b late after long open");
   property p_pready; (i_psel && !i_penable) |=> o_pready ##1 !o_pready; endproperty
   a_pready: assert property (p_pready)
      else $error("pready not one cycle after setup");
   property p_alarm; $rose(o_timing_alarm) |-> !o_base_drive_en; endproperty
   a_alarm: assert property (p_alarm)
      else $error("alarm without torque off");
endmodule

bind safe_torque_off_monitor sto_monitor_checker u_chk (.i_mclk(i_mclk), .i_resetn(i_resetn),
   .i_shutoff_in_a(i_shutoff_in_a), .i_shutoff_in_b(i_shutoff_in_b), .i_psel(i_psel),
   .i_penable(i_penable), .o_pready(o_pready), .o_base_drive_en(o_base_drive_en),
   .o_torque_off_mon_a(o_torque_off_mon_a), .o_torque_off_mon_b(o_torque_off_mon_b),
   .o_torque_off_mon_common(o_torque_off_mon_common), .o_timing_alarm(o_timing_alarm));

// >>> verification/testbench.sv
// bench: monitor with safety unit model, apb master tasks, row table
// assumes package, design, checker and model compile first
`timescale 1ns/100ps
module testbench;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic clk, rstn, req_a, req_b, pulse, decel, psel, pen, pwr, ca, cb;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, base_en, mon_a, mon_b, mon_c, dec_act, alarm, irq, err;
   int fails, comparisons;
   typedef struct {int w; logic [11:0] a; logic [31:0] d; logic [31:0] e; int er;} row_t;
   row_t rows [10]; // register accesses and expected answers
   safety_unit_model #(.PULSE_CYC(1000)) u_unit (.i_mclk(clk), .i_off_a_req(req_a),
      .i_off_b_req(req_b), .i_pulse(pulse), .o_contact_a(ca), .o_contact_b(cb));
   safe_torque_off_monitor DUT (.i_mclk(clk), .i_resetn(rstn), .i_shutoff_in_a(ca),
      .i_shutoff_in_b(cb), .i_forced_stop_decel_in(decel), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .o_base_drive_en(base_en),
      .o_torque_off_mon_a(mon_a), .o_torque_off_mon_b(mon_b),
      .o_torque_off_mon_common(mon_c), .o_decel_active(dec_act),
      .o_timing_alarm(alarm), .o_irq(irq));
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   // verdict and end of run
   task automatic end_sim();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // compare and report
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one apb transfer; answer taken at the edge that shows pready
   task automatic apb(input int w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= (w != 0);
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      if (pready !== 1'b1)
      begin
         chk("pready", 32'h0000_0001, 32'(pready));
         end_sim();
      end
   endtask
   // bounded wait for a monitor output to turn on
   task automatic wait_mon(input logic b, input int lim);
      int n;
      n = 0;
      while ((b ? mon_b : mon_a) !== 1'b1 && n < lim)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= lim)
      begin
         chk("monitor wait", 32'h0000_0001, 32'h0000_0000);
         end_sim();
      end
   endtask
   // ------------------------------------------------------------
   // clock and sequence
   // ------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      fails = 0;
      comparisons = 0;
      {rstn, req_a, req_b, pulse, decel, psel, pen, pwr} = 8'h00;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      rows = '{'{1, sto_monitor_pkg::ADDR_IRQ_CLR, 32'h0000_000F, 32'h0000_0000, 0},
         '{0, sto_monitor_pkg::ADDR_IRQ_STAT, 32'h0000_0000, 32'h0000_0000, 0},
         '{0, sto_monitor_pkg::ADDR_STATE, 32'h0000_0000, 32'h0000_0010, 0},
         '{1, sto_monitor_pkg::ADDR_CTRL, 32'h0000_0003, 32'h0000_0000, 0},
         '{0, sto_monitor_pkg::ADDR_CTRL, 32'h0000_0000, 32'h0000_0003, 0},
         '{0, sto_monitor_pkg::ADDR_STATE, 32'h0000_0000, 32'h0000_0000, 0},
         '{1, sto_monitor_pkg::ADDR_CTRL, 32'h0000_0001, 32'h0000_0000, 0},
         '{1, sto_monitor_pkg::ADDR_IRQ_EN, 32'h0000_000F, 32'h0000_0000, 0},
         '{0, sto_monitor_pkg::ADDR_IRQ_EN, 32'h0000_0000, 32'h0000_000F, 0},
         '{0, 12'h020, 32'h0000_0000, 32'h0000_0000, 1}};
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      repeat (8) @(posedge clk);
      #1;
      chk("released outputs", 32'h0000_0008, {base_en, mon_a, mon_b, mon_c});
      foreach (rows[i])
      begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         chk("read data", rows[i].e, rd);
         chk("slave error", 32'(rows[i].er), 32'(err));
      end
      // short test pulse on both contacts is ignored
      pulse <= 1'b1;
      @(posedge clk);
      pulse <= 1'b0;
      repeat (1100) @(posedge clk);
      #1;
      chk("pulse outputs", 32'h0000_0008, {base_en, mon_a, mon_b, mon_c});
      apb(0, sto_monitor_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
      chk("pulse events", 32'h0000_0000, rd);
      // contact a opens alone while rotating, b follows later
      req_a <= 1'b1;
      repeat (1500) @(posedge clk);
      req_b <= 1'b1;
      wait_mon(1'b0, 100100);
      chk("one off", 32'h0000_0004, {base_en, mon_a, mon_b, mon_c});
      apb(0, sto_monitor_pkg::ADDR_STATE, 32'h0000_0000);
      chk("state one off", 32'h0000_0035, rd);
      chk("alarm", 32'h0000_0001, 32'(alarm));
      chk("irq raised", 32'h0000_0001, 32'(irq));
      apb(1, sto_monitor_pkg::ADDR_IRQ_EN, 32'h0000_0000);
      apb(0, sto_monitor_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
      chk("events", 32'h0000_000D, rd);
      chk("irq masked", 32'h0000_0000, 32'(irq));
      apb(1, sto_monitor_pkg::ADDR_IRQ_CLR, 32'h0000_000F);
      apb(1, sto_monitor_pkg::ADDR_CTRL, 32'h0000_0004);
      apb(1, sto_monitor_pkg::ADDR_IRQ_EN, 32'h0000_000F);
      chk("irq cleared", 32'h0000_0000, 32'(irq));
      chk("alarm cleared", 32'h0000_0000, 32'(alarm));
      wait_mon(1'b1, 3000);
      chk("both off", 32'h0000_0007, {base_en, mon_a, mon_b, mon_c});
      apb(0, sto_monitor_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
      chk("events both", 32'h0000_0002, rd);
      chk("no alarm", 32'h0000_0000, 32'(alarm));
      req_a <= 1'b0;
      req_b <= 1'b0;
      decel <= 1'b1;
      repeat (8) @(posedge clk);
      #1;
      chk("release", 32'h0000_0008, {base_en, mon_a, mon_b, mon_c});
      chk("decel", 32'h0000_0001, 32'(dec_act));
      apb(1, sto_monitor_pkg::ADDR_CTRL, 32'h0000_0002);
      repeat (4) @(posedge clk);
      #1;
      chk("decel torque mode", 32'h0000_0000, 32'(dec_act));
      // second reset in mid-run
      @(posedge clk);
      rstn <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk("in reset", 32'h0000_0007, {base_en, mon_a, mon_b, mon_c});
      @(posedge clk);
      rstn <= 1'b1;
      repeat (8) @(posedge clk);
      #1;
      chk("after reset", 32'h0000_0008, {base_en, mon_a, mon_b, mon_c});
      end_sim();
   end
endmodule
